// ==== dv/mbx_master_model.sv ====
/* master-side sink model: takes answer bytes into a queue.
   assumes the bench seeds the random source and reads got. */
module mbx_master_model (
    // clock
    input  wire logic       clk,
    // answer byte stream
    input  wire logic       tx_valid,
    output      logic       tx_ready,
    input  wire logic [7:0] tx_data,
    // stall control
    input  wire logic       slow
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got [$];
    initial tx_ready = 1'b0;
    // a busy master holds off at random, so the hold path is exercised
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= #1 !slow || $urandom_range(1);
    end
endmodule : mbx_master_model

// ==== dv/mbx_responder_bench.sv ====
/* self-checking bench for the responder: directed causes, unlock
   sequence, then random requests. assumes the sink model in dv/. */
module mbx_responder_bench;
    import mbx_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] CLEAN = 14'h3F81;
    logic clk, sys_rst, req_valid, req_ready, req_is_write, relock, slow;
    logic [7:0] req_slave, req_func, tx_data, resp_code;
    logic [15:0] req_addr, req_word, user_password_parameter;
    logic rtu_mode, frame_len_ok, frame_crc_ok, func_supported, access_ok;
    logic value_ok, param_value_ok, param_read_only, param_run_locked;
    logic pass_access, drive_fault, drive_running, sys_locked;
    logic tx_valid, tx_ready, tx_last, resp_done, resp_exc, unlocked, unl;
    logic [13:0] fl;
    int n_errors = 0;
    int num_checks = 0;
    assign {rtu_mode, frame_len_ok, frame_crc_ok, func_supported, access_ok,
            value_ok, param_value_ok, param_read_only, param_run_locked,
            pass_access, drive_fault, drive_running, sys_locked,
            req_is_write} = fl;
    always #5 clk = ~clk;
    mbx_responder u_dut (.*);
    mbx_master_model u_mst (.clk, .tx_valid, .tx_ready, .tx_data, .slow);

    task automatic close_out;
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    // same priority order the designer chose; first match wins
    function automatic logic [7:0] cause(input logic [13:0] f,
                                         input logic [15:0] w);
        if (!f[12] || (f[13] && !f[11])) return EXC_BAD_FRAME;
        if (!f[10] || f[3]) return EXC_BAD_CMD;
        if (f[1] && !unl && !f[4]) return EXC_SYS_LOCKED;
        if (!f[9]) return EXC_BAD_ADDR;
        if (!f[8]) return EXC_BAD_VALUE;
        if (f[4] && f[0] && w != user_password_parameter) return EXC_BAD_PASS;
        if (f[0] && f[6]) return EXC_READ_ONLY;
        if (f[0] && f[5] && f[2]) return EXC_RUN_LOCKED;
        if (f[0] && !f[7]) return EXC_OP_FAIL;
        return EXC_NONE;
    endfunction : cause

    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] r;
        r = CRC_INIT;
        foreach (b[i]) begin
            r ^= {8'h00, b[i]};
            repeat (8) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc16

    function automatic logic [13:0] flip(input int k);
        if (k == 13) return 14'h0024;
        if (k == 14) return 14'h1FFE;
        return 14'(1 << k) & 14'h1FFE;
    endfunction : flip

    task automatic ask(input logic [13:0] f, input logic [15:0] w);
        logic [7:0] c;
        logic [7:0] e [$];
        logic [15:0] r;
        int n;
        c = cause(f, w);
        req_slave = 8'($urandom);
        req_func = 8'($urandom);
        req_addr = 16'($urandom);
        req_word = w;
        fl = f;
        req_valid = 1'b1;
        u_mst.got.delete();
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1 req_valid = 1'b0;
        n = 0;
        while (resp_done !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        if (resp_done !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t no answer finished in time", $time);
        end
        if (c == EXC_NONE && f[4] && f[0] && w == user_password_parameter)
            unl = 1'b1;
        e = {req_slave, (c != EXC_NONE) ? (req_func | FC_EXC_MASK) : req_func};
        if (c != EXC_NONE)
            e.push_back(c);
        else
            e = {e, req_addr[15:8], req_addr[7:0], w[15:8], w[7:0]};
        r = crc16(e);
        foreach (e[i]) chk(u_mst.got[i], e[i]);
        if (f[13]) begin
            chk(u_mst.got[e.size()], r[7:0]);
            chk(u_mst.got[$], r[15:8]);
        end
        n = e.size() + (f[13] ? 2 : 0);
        chk(16'(u_mst.got.size()), 16'(n));
        chk(resp_code, c);
        chk(resp_exc, c != EXC_NONE);
        chk(unlocked, unl);
    endtask : ask

    initial begin
        logic [13:0] f;
        clk = 1'b0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        relock = 1'b0;
        slow = 1'b0;
        fl = CLEAN;
        {req_slave, req_func, req_addr, req_word} = 48'h0;
        user_password_parameter = 16'h5A3C;
        unl = 1'b0;
        void'($urandom(32'h3AC6));
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (int k = 0; k < 30; k++) begin
            slow = 1'(k);
            f = CLEAN ^ flip(k % 15);
            f[13] = k < 15;
            ask(f, 16'($urandom));
        end
        ask(CLEAN | 14'h0002, 16'h1234);
        ask(CLEAN | 14'h0012, ~user_password_parameter);
        ask(CLEAN | 14'h0012, user_password_parameter);
        ask(14'h3F82, 16'h0000);
        relock = 1'b1;
        @(posedge clk);
        #1 relock = 1'b0;
        unl = 1'b0;
        ask(CLEAN | 14'h0002, 16'h0000);
        for (int k = 0; k < 60; k++) begin
            slow = 1'($urandom);
            f = CLEAN ^ (14'($urandom & $urandom & $urandom) & 14'h1FEF);
            f[13] = 1'($urandom);
            ask(f, 16'($urandom));
        end
        close_out();
    end

    // about 100 requests of under 30 cycles each; this is more than six times that
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule : mbx_responder_bench

// ==== dv/mbx_responder_chk.sv ====
/* timing and framing checks on the responder's ports.
   assumes single clock, sync active-high reset. */
module mbx_responder_chk
    import mbx_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // request
    input  wire logic        req_valid,
    input  wire logic        req_ready,
    input  wire logic [7:0]  req_slave,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_addr,
    input  wire logic        frame_len_ok,
    // answer
    input  wire logic        tx_valid,
    input  wire logic        tx_ready,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_last,
    input  wire logic        resp_done,
    input  wire logic        resp_exc,
    input  wire logic [7:0]  resp_code
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] idx;
    logic [7:0] slv, fnc, ahi;
    wire take = req_valid && req_ready;
    wire acc  = tx_valid && tx_ready;
    // byte index saturates: only the first three positions are checked
    always_ff @(posedge clk) begin
        if (sys_rst || take)
            idx <= 3'h0;
        else if (acc && idx != 3'h7)
            idx <= idx + 3'h1;
        if (take) begin
            slv <= req_slave;
            fnc <= req_func;
            ahi <= req_addr[15:8];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_SLAVE_FIRST: assert property (
        tx_valid && idx == 3'h0 |-> tx_data == slv)
        else $error("first byte is not the slave address");
    AST_FUNC_ECHO: assert property (
        tx_valid && !resp_exc && idx == 3'h1 |-> tx_data == fnc)
        else $error("normal answer lost the function code");
    AST_ADDR_ECHO: assert property (
        tx_valid && !resp_exc && idx == 3'h2 |-> tx_data == ahi)
        else $error("normal answer lost the address");
    AST_FUNC_MARK: assert property (
        tx_valid && resp_exc && idx == 3'h1 |-> tx_data == (fnc | FC_EXC_MASK))
        else $error("exception function code not marked");
    AST_CAUSE_BYTE: assert property (
        tx_valid && resp_exc && idx == 3'h2 |-> tx_data == resp_code)
        else $error("cause byte differs from resp_code");
    AST_BAD_FRAME: assert property (
        take && !frame_len_ok |=> resp_exc && resp_code == EXC_BAD_FRAME)
        else $error("bad length not answered with 06");
    AST_CODE_FLAG: assert property (
        take |=> resp_exc == (resp_code != EXC_NONE))
        else $error("resp_exc disagrees with resp_code");
    AST_ANSWER_LAT: assert property (
        take |=> !req_ready ##1 tx_valid)
        else $error("answer not started two cycles after take");
    AST_HOLD: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte changed while stalled");
    AST_DONE: assert property (
        acc && tx_last |=> resp_done && !tx_valid)
        else $error("no done pulse after last byte");
endmodule : mbx_responder_chk

bind mbx_responder mbx_responder_chk u_chk (.*);

// ==== src/mbx_crc.sv ====
/*
 * byte-wide crc-16 accumulator, one byte per clock.
 * assumes clear and step are never asserted together on purpose;
 * clear wins if they are.
 */
module mbx_crc
    import mbx_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control side
    mbx_crc_if.unit   cif
);

    logic [15:0] crc;
    logic [15:0] next_crc;

    assign cif.crc = crc;

    always_comb begin
        next_crc = crc ^ {8'h00, cif.data};
        for (int i = 0; i < 8; i++) begin
            if (next_crc[0]) begin
                next_crc = (next_crc >> 1) ^ CRC_POLY;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || cif.clear) begin
            crc <= CRC_INIT;
        end else if (cif.step) begin
            crc <= next_crc;
        end
    end

endmodule : mbx_crc

// ==== src/mbx_crc_if.sv ====
/*
 * carrier between the responder and its crc unit.
 * assumes both ends share one clock.
 */
interface mbx_crc_if;
    logic        clear;
    logic        step;
    logic [7:0]  data;
    logic [15:0] crc;

    modport ctrl (output clear, output step, output data, input crc);
    modport unit (input clear, input step, input data, output crc);
endinterface : mbx_crc_if

// ==== src/mbx_pkg.sv ====
/*
 * constants shared by the exception responder and its crc unit.
 * assumes nothing of its surroundings.
 */
package mbx_pkg;

    // exception cause codes
    localparam logic [7:0] EXC_BAD_CMD    = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR   = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE  = 8'h03;
    localparam logic [7:0] EXC_OP_FAIL    = 8'h04;
    localparam logic [7:0] EXC_BAD_PASS   = 8'h05;
    localparam logic [7:0] EXC_BAD_FRAME  = 8'h06;
    localparam logic [7:0] EXC_READ_ONLY  = 8'h07;
    localparam logic [7:0] EXC_RUN_LOCKED = 8'h08;
    localparam logic [7:0] EXC_SYS_LOCKED = 8'h09;
    localparam logic [7:0] EXC_NONE       = 8'h00;

    // function code marking
    localparam logic [7:0] FC_EXC_MASK    = 8'h80;

    // frame lengths without check field, and byte positions
    localparam logic [2:0] NORM_LEN       = 3'h6;
    localparam logic [2:0] EXC_LEN        = 3'h3;
    localparam logic [2:0] POS_SLAVE      = 3'h0;
    localparam logic [2:0] POS_FUNC       = 3'h1;
    localparam logic [2:0] POS_B2         = 3'h2;
    localparam logic [2:0] POS_B3         = 3'h3;
    localparam logic [2:0] POS_B4         = 3'h4;
    localparam logic [2:0] IDX_ONE        = 3'h1;

    // crc-16 as used on rtu links, reflected form
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'hA001;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_LOAD   = 4'h2,
        ST_SEND   = 4'h4,
        ST_CRC_HI = 4'h8
    } mbx_state_type;

endpackage : mbx_pkg

// ==== src/mbx_responder.sv ====
/*
 * slave-side error classification and response framing for a serial
 * drive link: takes one decoded request, picks normal or exception
 * answer and streams the answer bytes out.
 * assumes the receiver has already decoded the request and checked its
 * frame; the byte sink honours valid/ready; ascii coding is done outside.
 */
// How it works
// R01: an unknown function code or a drive fault gives cause 01H.
// R02: an illegal address and byte count pair gives cause 02H.
// R03: a data value the rest of the request forbids gives cause 03H.
// R04: a write of an invalid parameter value gives cause 04H.
// R05: a password unlike the stored user password gives cause 05H.
// R06: a bad frame length, or a bad crc in rtu mode, gives cause 06H.
// R07: a write to a read-only parameter gives cause 07H.
// R08: a write to a run-locked parameter while running gives cause 08H.
// R09: any access but a password access while locked and not unlocked gives cause 09H.
// R10: a normal answer echoes the function code and data address.
// R11: an exception answer returns the function code with top bit set.
// R12: an exception answer carries one cause byte after the code.
// R13: the master resends or changes its request after an exception.
// R14: rtu exception frame: address, marked code, cause, fresh crc.
module mbx_responder
    import mbx_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // decoded request
    input  wire logic        req_valid,
    output      logic        req_ready,
    input  wire logic [7:0]  req_slave,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_word,
    input  wire logic        req_is_write,
    // frame checks from the receiver
    input  wire logic        rtu_mode,
    input  wire logic        frame_len_ok,
    input  wire logic        frame_crc_ok,
    // request classification from the parameter decoder
    input  wire logic        func_supported,
    input  wire logic        access_ok,
    input  wire logic        value_ok,
    input  wire logic        param_value_ok,
    input  wire logic        param_read_only,
    input  wire logic        param_run_locked,
    // password handling
    input  wire logic        pass_access,
    input  wire logic [15:0] user_password_parameter,
    input  wire logic        relock,
    // drive state
    input  wire logic        drive_fault,
    input  wire logic        drive_running,
    input  wire logic        sys_locked,
    // answer byte stream
    output      logic        tx_valid,
    input  wire logic        tx_ready,
    output      logic [7:0]  tx_data,
    output      logic        tx_last,
    // answer summary
    output      logic        resp_done,
    output      logic        resp_exc,
    output      logic [7:0]  resp_code,
    output      logic        unlocked
);

    mbx_crc_if     cif ();
    mbx_state_type state;
    mbx_state_type next_state;

    // latched request and answer byte index
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] word;
    logic        rtu;
    logic [2:0]  idx;

    // classification of the incoming request; the cause select below sets the priority
    // req_ready is low for one cycle after reset, so it must gate the take
    wire take       = (state == ST_IDLE) && req_ready && req_valid;
    wire bad_frame  = !frame_len_ok || (rtu_mode && !frame_crc_ok); // see R06
    wire bad_cmd    = !func_supported || drive_fault;               // see R01
    wire pass_match = (req_word == user_password_parameter);
    wire bad_pass   = pass_access && req_is_write && !pass_match;   // see R05
    // the password access itself must pass the lock, else no unlock
    wire locked_out = sys_locked && !unlocked && !pass_access;      // see R09
    wire bad_addr   = !access_ok;                                   // see R02
    wire bad_value  = !value_ok;                                    // see R03
    wire ro_write   = req_is_write && param_read_only;              // see R07
    wire run_write  = req_is_write && param_run_locked
                      && drive_running;                             // see R08
    wire bad_param  = req_is_write && !param_value_ok;              // see R04

    wire [7:0] cause =
        bad_frame  ? EXC_BAD_FRAME  :
        bad_cmd    ? EXC_BAD_CMD    :
        locked_out ? EXC_SYS_LOCKED :
        bad_addr   ? EXC_BAD_ADDR   :
        bad_value  ? EXC_BAD_VALUE  :
        bad_pass   ? EXC_BAD_PASS   :
        ro_write   ? EXC_READ_ONLY  :
        run_write  ? EXC_RUN_LOCKED :
        bad_param  ? EXC_OP_FAIL    :
                     EXC_NONE;
    wire is_exc  = (cause != EXC_NONE);
    wire unlock  = take && !is_exc && pass_access && req_is_write;

    // answer byte selection
    wire [2:0] len      = resp_exc ? EXC_LEN : NORM_LEN;
    wire       at_end   = (idx == len);
    wire       accepted = tx_valid && tx_ready;
    wire [7:0] func_out = resp_exc ? (func | FC_EXC_MASK) : func; // see R11
    wire [7:0] b2       = resp_exc ? resp_code : addr[15:8];     // see R12
    wire [7:0] pay_byte =
        (idx == POS_SLAVE) ? slave     :                         // see R14
        (idx == POS_FUNC)  ? func_out  :                         // see R10
        (idx == POS_B2)    ? b2        :
        (idx == POS_B3)    ? addr[7:0] :
        (idx == POS_B4)    ? word[15:8] :
                             word[7:0];

    wire load_pay  = (state == ST_LOAD)
                     || ((state == ST_SEND) && accepted && !at_end);
    wire send_lo   = (state == ST_SEND) && accepted && at_end && rtu;
    wire send_hi   = (state == ST_CRC_HI) && accepted && !tx_last;
    wire finish    = ((state == ST_SEND) && accepted && at_end && !rtu)
                     || ((state == ST_CRC_HI) && accepted && tx_last);
    wire last_pay  = (idx == (len - IDX_ONE)) && !rtu;

    // crc steps when a byte is put on the stream, so it is ready
    // one cycle before the check field is needed
    assign cif.clear = take;
    assign cif.step  = load_pay;
    assign cif.data  = pay_byte;

    mbx_crc u_crc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cif     (cif)
    );

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_SEND;
            end
            ST_SEND: begin
                if (send_lo) begin
                    next_state = ST_CRC_HI;
                end else if (finish) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CRC_HI: begin
                if (finish) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            req_ready <= 1'b0;
        end else begin
            state     <= next_state;
            req_ready <= (next_state == ST_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slave     <= 8'h00;
            func      <= 8'h00;
            addr      <= 16'h0000;
            word      <= 16'h0000;
            rtu       <= 1'b0;
            resp_exc  <= 1'b0;
            resp_code <= EXC_NONE;
        end else if (take) begin
            slave     <= req_slave;
            func      <= req_func;
            addr      <= req_addr;
            word      <= req_word;
            rtu       <= rtu_mode;
            resp_exc  <= is_exc;
            resp_code <= cause;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || take) begin
            idx <= POS_SLAVE;
        end else if (load_pay) begin
            idx <= idx + IDX_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else if (load_pay) begin
            tx_valid <= 1'b1;
            tx_data  <= pay_byte;
            tx_last  <= last_pay;
        end else if (send_lo) begin
            tx_data  <= cif.crc[7:0];                            // see R14
            tx_last  <= 1'b0;
        end else if (send_hi) begin
            // low check byte taken; crc holds still, so the high half is safe
            tx_data  <= cif.crc[15:8];                           // see R14
            tx_last  <= 1'b1;
        end else if (finish) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_done <= 1'b0;
        end else begin
            resp_done <= finish;
        end
    end

    // unlock only lasts until the drive relocks; a correct password in
    // the same cycle as relock keeps the system unlocked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unlocked <= 1'b0;
        end else if (unlock) begin
            unlocked <= 1'b1;                                    // see R09
        end else if (relock) begin
            unlocked <= 1'b0;
        end
    end

endmodule : mbx_responder
